// >>> rtl/edt_defines.svh
// Constants for the enclave debug and trace gating block.
`ifndef EDT_DEFINES_SVH
`define EDT_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EDT_OFF_CTRL      8'h00
`define EDT_OFF_STATUS    8'h04
`define EDT_OFF_DBGSTAT   8'h08
`define EDT_OFF_EXITSTATE 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EDT_CTRL_LBR_EN   0
`define EDT_CTRL_BTF_EN   1
`define EDT_CTRL_FAR_FILT 8
`define EDT_ST_IN_ENCL    0
`define EDT_ST_OPTIN      1
`define EDT_ST_LBR_SUPP   2
`define EDT_ST_LBR_ARMED  3
`define EDT_XS_SAVED_RF   0
`define EDT_XS_SYNTH_RF   1
`define EDT_SRC_PRED_BIT  63

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EDT_CTRL_RST      32'h0000_0000
`define EDT_DBGSTAT_RST   4'h0

// ----------------------------------------
// Opcodes, vectors and event types
// ----------------------------------------
`define EDT_OPC_ICEBP     8'hf1
`define EDT_OPC_BKPT      8'hcc
`define EDT_OPC_INTN      8'hcd
`define EDT_VEC_DEBUG     8'h01
`define EDT_VEC_BKPT      8'h03
`define EDT_VEC_INVOP     8'h06
`define EDT_EVT_HW_EXC    3'h3
`define EDT_ILEN_ZERO     4'h0

`endif

// >>> rtl/edt_pkg.sv
// Types shared by the enclave debug and trace gating block.
package edt_pkg;

   typedef enum logic [2:0] {
      EDT_EV_NONE,
      EDT_EV_ENTER,
      EDT_EV_RESUME,
      EDT_EV_EXIT,
      EDT_EV_AEX,
      EDT_EV_BRANCH
   } edt_ev_e;

   typedef struct packed {
      edt_ev_e     kind;
      logic        optin_flag;
      logic [63:0] instr_ip;
      logic [63:0] dest_ip;
      logic [63:0] ssa_ip;
      logic [63:0] async_exit_pointer;
      logic        cause_push;
      logic [63:0] cause_to;
      logic        rf_push;
   } edt_event_s;

   typedef struct packed {
      logic        valid;
      logic [3:0]  dbp_match;
      logic        in_range;
      logic        epc_operand;
      logic        implicit_acc;
      logic        keyrep_leaf;
   } edt_daccess_s;

   typedef struct packed {
      logic        valid;
      logic [63:0] from_ip;
      logic [63:0] to_ip;
      logic        far_br;
      logic        in_tx;
   } edt_lbr_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic [2:0]  ev_type;
      logic [3:0]  instr_len;
      logic        skip_dpl;
      logic [63:0] ssa_ip;
      logic [63:0] stack_ip;
   } edt_exc_s;

endpackage

// >>> rtl/edt_gate.sv
// Enclave debug and trace gating with a classic Wishbone register slave.
//
// Function
// - Opt-in flag selects opt-in or opt-out entry.
// - Opt-out hides instruction breakpoints inside enclave.
// - Opt-out hides in-range data breakpoints only.
// - Opt-in keeps instruction and in-range data breakpoints active.
// - Suppressed matches unrecorded; old status kept.
// - Debug trap exits; report exit-pointer breakpoint matches.
// - Save outside resume flag; clear synthetic one.
// - No data breakpoints on page cache leaf accesses.
// - Key/report opt-in and non-cache operands still fire.
// - Only opcodes F1 and CC get trap handling.
// - Opt-out one-byte traps become invalid opcode.
// - Opt-in traps fault; vector 3 privilege skipped.
// - Saved pointer at trap; delivered pointer exit pointer.
// - Trap VM exit: type 3, length zero.
// - Branch stepping after opt-in enter and exit.
// - Opt-in pushes entry, exit, inner branch records.
// - Opt-in exit event records saved pointer to exit.
// - Opt-out suppresses recording until exit.
// - Opt-out exit leaf pushes one entry record.
// - Opt-out async exit pushes entry-to-pointer first.
// - Far enclave records predicted, bit 63; all non-transactional.
// - Enter/exit records far, filtered by bit 8; branch records near.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "edt_defines.svh"

module edt_gate (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire edt_pkg::edt_event_s   event_i,
   input  wire logic [3:0]       ibp_match_i,
   input  wire logic [3:0]       aep_ibp_match_i,
   input  wire edt_pkg::edt_daccess_s daccess_i,
   input  wire logic             single_step_i,
   input  wire logic             trap_valid_i,
   input  wire logic [7:0]       trap_opcode_i,
   input  wire logic [63:0]      trap_ip_i,
   output logic      [3:0]       ibp_fire_o,
   output logic      [3:0]       dbp_fire_o,
   output logic                  aex_req_o,
   output logic                  btf_step_o,
   output logic                  lbr_suppress_o,
   output edt_pkg::edt_lbr_s     lbr_rec_o,
   output edt_pkg::edt_exc_s     trap_exc_o
);
   import edt_pkg::*;

   // ----------------------------------------
   // Enclave mode tracking
   // ----------------------------------------
   logic        in_enclave;
   logic        optin;
   logic        lbr_armed;
   logic [63:0] entry_ip;
   logic [31:0] ctrl;
   logic        is_entry;
   logic        is_leave;
   logic        optout_in;

   assign is_entry  = (event_i.kind == EDT_EV_ENTER) || (event_i.kind == EDT_EV_RESUME);
   assign is_leave  = (event_i.kind == EDT_EV_EXIT) || (event_i.kind == EDT_EV_AEX);
   assign optout_in = in_enclave && !optin;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_enclave <= 1'b0;
         optin      <= 1'b0;
         lbr_armed  <= 1'b0;
         entry_ip   <= 64'h0;
      end else if (is_entry) begin
         in_enclave <= 1'b1;
         optin      <= event_i.optin_flag;
         lbr_armed  <= ctrl[`EDT_CTRL_LBR_EN];
         entry_ip   <= event_i.instr_ip;
      end else if (is_leave) begin
         in_enclave <= 1'b0;
         optin      <= 1'b0;
         lbr_armed  <= 1'b0;
      end
   end

   assign lbr_suppress_o = optout_in;

   // ----------------------------------------
   // Breakpoint gating
   // ----------------------------------------
   logic dacc_allowed;

   always_comb begin
      ibp_fire_o = optout_in ? 4'h0 : ibp_match_i;
      dacc_allowed = !daccess_i.epc_operand;
      // key and report leaves after opt-in
      if (daccess_i.epc_operand && !daccess_i.implicit_acc && daccess_i.keyrep_leaf &&
          in_enclave && optin) begin
         dacc_allowed = 1'b1;
      end
      if (optout_in && daccess_i.in_range) begin
         dacc_allowed = 1'b0;
      end
      dbp_fire_o = (daccess_i.valid && dacc_allowed) ? daccess_i.dbp_match : 4'h0;
   end

   // debug trap inside enclave asks for an exit
   assign aex_req_o = in_enclave && (single_step_i || (|dbp_fire_o));

   // ----------------------------------------
   // Debug status and resume flag
   // ----------------------------------------
   logic [3:0] dbg_status;
   logic       saved_rf;
   logic       synth_rf;
   logic       wr_dbgstat;
   logic       wr_ctrl;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dbg_status <= `EDT_DBGSTAT_RST;
      end else begin
         // fired and async exit pointer matches set; only a status write clears
         dbg_status <= (wr_dbgstat ? (dbg_status & wb_dat_i[3:0]) : dbg_status) |
                       ibp_fire_o | dbp_fire_o |
                       ((event_i.kind == EDT_EV_AEX) ? aep_ibp_match_i : 4'h0);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_rf <= 1'b0;
         synth_rf <= 1'b0;
      end else if (event_i.kind == EDT_EV_AEX) begin
         saved_rf <= event_i.rf_push;
         synth_rf <= 1'b0;
      end else if (is_entry) begin
         synth_rf <= 1'b1;
      end
   end

   // ----------------------------------------
   // One-byte trap handling
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trap_exc_o <= '0;
      end else begin
         trap_exc_o.valid <= 1'b0;
         if (trap_valid_i && in_enclave &&
             (trap_opcode_i == `EDT_OPC_ICEBP || trap_opcode_i == `EDT_OPC_BKPT)) begin
            trap_exc_o.valid <= 1'b1;
            if (!optin) begin
               trap_exc_o.vector <= `EDT_VEC_INVOP;
            end else if (trap_opcode_i == `EDT_OPC_ICEBP) begin
               trap_exc_o.vector <= `EDT_VEC_DEBUG;
            end else begin
               trap_exc_o.vector <= `EDT_VEC_BKPT;
            end
            trap_exc_o.skip_dpl  <= optin && (trap_opcode_i == `EDT_OPC_BKPT);
            trap_exc_o.ev_type   <= `EDT_EVT_HW_EXC;
            trap_exc_o.instr_len <= `EDT_ILEN_ZERO;
            trap_exc_o.ssa_ip    <= trap_ip_i;
            trap_exc_o.stack_ip  <= event_i.async_exit_pointer;
         end
      end
   end

   // ----------------------------------------
   // Branch stepping
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         btf_step_o <= 1'b0;
      end else begin
         // opt-in enter and exit leaf only
         btf_step_o <= ctrl[`EDT_CTRL_BTF_EN] &&
                       (((event_i.kind == EDT_EV_ENTER) && event_i.optin_flag) ||
                        (event_i.kind == EDT_EV_EXIT));
      end
   end

   // ----------------------------------------
   // Branch record generation
   // ----------------------------------------
   logic        pend2;
   logic [63:0] pend2_from;
   logic [63:0] pend2_to;
   logic        rec_ok;
   edt_lbr_s    next_rec;
   logic        next_pend2;

   // far records dropped when bit 8 is set
   assign rec_ok = ctrl[`EDT_CTRL_LBR_EN] && !ctrl[`EDT_CTRL_FAR_FILT];

   always_comb begin
      next_rec        = '0;
      next_pend2      = 1'b0;
      next_rec.far_br = 1'b1;
      if (pend2) begin
         // causing event record from exit pointer
         next_rec.valid   = 1'b1;
         next_rec.from_ip = pend2_from;
         next_rec.to_ip   = pend2_to;
      end else if (is_entry && event_i.optin_flag && rec_ok) begin
         next_rec.valid   = 1'b1;
         next_rec.from_ip = event_i.instr_ip;
         next_rec.to_ip   = event_i.dest_ip;
      end else if (event_i.kind == EDT_EV_BRANCH && in_enclave && optin &&
                   ctrl[`EDT_CTRL_LBR_EN]) begin
         next_rec.valid   = 1'b1;
         next_rec.far_br  = 1'b0;
         next_rec.from_ip = event_i.instr_ip;
         next_rec.to_ip   = event_i.dest_ip;
      end else if (event_i.kind == EDT_EV_EXIT && in_enclave && optin && rec_ok) begin
         next_rec.valid   = 1'b1;
         next_rec.from_ip = event_i.instr_ip;
         next_rec.to_ip   = event_i.dest_ip;
      end else if (event_i.kind == EDT_EV_AEX && in_enclave && optin && rec_ok) begin
         next_rec.valid   = 1'b1;
         next_rec.from_ip = event_i.ssa_ip;
         next_rec.to_ip   = event_i.async_exit_pointer;
      end else if (event_i.kind == EDT_EV_EXIT && optout_in && lbr_armed &&
                   !ctrl[`EDT_CTRL_FAR_FILT]) begin
         next_rec.valid   = 1'b1;
         next_rec.from_ip = entry_ip;
         next_rec.to_ip   = event_i.dest_ip;
      end else if (event_i.kind == EDT_EV_AEX && optout_in && lbr_armed &&
                   !ctrl[`EDT_CTRL_FAR_FILT]) begin
         next_rec.valid   = 1'b1;
         next_rec.from_ip = entry_ip;
         next_rec.to_ip   = event_i.async_exit_pointer;
         next_pend2       = event_i.cause_push;
      end
      if (next_rec.far_br) begin
         next_rec.from_ip[`EDT_SRC_PRED_BIT] = 1'b1;
      end
      next_rec.in_tx = 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lbr_rec_o  <= '0;
         pend2      <= 1'b0;
         pend2_from <= 64'h0;
         pend2_to   <= 64'h0;
      end else begin
         lbr_rec_o <= next_rec;
         pend2     <= next_pend2;
         if (next_pend2) begin
            pend2_from <= event_i.async_exit_pointer;
            pend2_to   <= event_i.cause_to;
         end
      end
   end

   // ----------------------------------------
   // Wishbone register slave
   // ----------------------------------------
   logic wb_req;

   assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl    = wb_req && wb_we_i && (wb_adr_i == `EDT_OFF_CTRL);
   assign wr_dbgstat = wb_req && wb_we_i && (wb_adr_i == `EDT_OFF_DBGSTAT) && wb_sel_i[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `EDT_CTRL_RST;
      end else if (wr_ctrl) begin
         if (wb_sel_i[0]) begin
            ctrl[`EDT_CTRL_LBR_EN] <= wb_dat_i[`EDT_CTRL_LBR_EN];
            ctrl[`EDT_CTRL_BTF_EN] <= wb_dat_i[`EDT_CTRL_BTF_EN];
         end
         if (wb_sel_i[1]) begin
            ctrl[`EDT_CTRL_FAR_FILT] <= wb_dat_i[`EDT_CTRL_FAR_FILT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
               `EDT_OFF_CTRL:      wb_dat_o <= ctrl;
               `EDT_OFF_STATUS: begin
                  wb_dat_o[`EDT_ST_IN_ENCL]   <= in_enclave;
                  wb_dat_o[`EDT_ST_OPTIN]     <= optin;
                  wb_dat_o[`EDT_ST_LBR_SUPP]  <= optout_in;
                  wb_dat_o[`EDT_ST_LBR_ARMED] <= lbr_armed;
               end
               `EDT_OFF_DBGSTAT:   wb_dat_o[3:0] <= dbg_status;
               `EDT_OFF_EXITSTATE: begin
                  wb_dat_o[`EDT_XS_SAVED_RF] <= saved_rf;
                  wb_dat_o[`EDT_XS_SYNTH_RF] <= synth_rf;
               end
               default:            wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_optout_ibp_hidden: assert property (optout_in |-> ibp_fire_o == 4'h0)
      else $error("instruction breakpoint fired after opt-out entry");
   chk_optout_drange: assert property (
      optout_in && daccess_i.in_range |-> dbp_fire_o == 4'h0)
      else $error("in-range data breakpoint fired after opt-out entry");
   chk_optin_ibp_kept: assert property (
      in_enclave && optin |-> ibp_fire_o == ibp_match_i)
      else $error("instruction breakpoint lost after opt-in entry");
   chk_status_sticky: assert property (
      !wr_dbgstat |=> (dbg_status & $past(dbg_status)) == $past(dbg_status))
      else $error("debug status bit cleared by hardware");
   chk_aep_report: assert property (
      event_i.kind == EDT_EV_AEX |=> (dbg_status & $past(aep_ibp_match_i))
                                      == $past(aep_ibp_match_i))
      else $error("exit pointer match not reported");
   chk_rf_synth: assert property (
      event_i.kind == EDT_EV_AEX |=> !synth_rf && saved_rf == $past(event_i.rf_push))
      else $error("resume flag handling on async exit wrong");
   chk_epc_quiet: assert property (
      daccess_i.epc_operand && daccess_i.implicit_acc |-> dbp_fire_o == 4'h0)
      else $error("implicit page cache access fired a breakpoint");
   chk_trap_optout: assert property (
      trap_valid_i && in_enclave && !optin && trap_opcode_i == `EDT_OPC_BKPT
      |=> trap_exc_o.valid && trap_exc_o.vector == `EDT_VEC_INVOP)
      else $error("opt-out trap not turned into invalid opcode");
   chk_intn_ignored: assert property (
      trap_valid_i && trap_opcode_i == `EDT_OPC_INTN |=> !trap_exc_o.valid)
      else $error("generic interrupt opcode got enclave handling");
   chk_trap_vmexit: assert property (
      trap_exc_o.valid |-> trap_exc_o.ev_type == `EDT_EVT_HW_EXC &&
                           trap_exc_o.instr_len == `EDT_ILEN_ZERO)
      else $error("trap exit encoding wrong");
   chk_btf_resume: assert property (
      event_i.kind == EDT_EV_RESUME || event_i.kind == EDT_EV_AEX |=> !btf_step_o)
      else $error("branch step after resume or async exit");
   chk_aex_two_push: assert property (
      event_i.kind == EDT_EV_AEX && optout_in && lbr_armed && event_i.cause_push &&
      !ctrl[`EDT_CTRL_FAR_FILT]
      |=> lbr_rec_o.valid && lbr_rec_o.to_ip == $past(event_i.async_exit_pointer)
      ##1 lbr_rec_o.valid && lbr_rec_o.from_ip[62:0] == $past(event_i.async_exit_pointer[62:0], 2))
      else $error("opt-out async exit record order wrong");
   chk_pred_bit: assert property (
      lbr_rec_o.valid && lbr_rec_o.far_br |-> lbr_rec_o.from_ip[63] && !lbr_rec_o.in_tx)
      else $error("enclave record not predicted or marked transactional");
   chk_far_filter: assert property (
      ctrl[`EDT_CTRL_FAR_FILT] && !pend2 |=> !(lbr_rec_o.valid && lbr_rec_o.far_br))
      else $error("far record pushed while filtered");

   cov_optin_entry: cover property (is_entry && event_i.optin_flag ##1 lbr_rec_o.valid);
   cov_optout_aex:  cover property (pend2 ##1 lbr_rec_o.valid);
   cov_trap_bkpt:   cover property (trap_exc_o.valid && trap_exc_o.vector == `EDT_VEC_BKPT);
   cov_aex_req:     cover property (aex_req_o);

endmodule

// >>> test/edt_vmm_model.sv
// Debugger and hypervisor model reacting to enclave trap reports.
`timescale 1ns/1ns

module edt_vmm_model (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire edt_pkg::edt_exc_s trap_exc_i,
   output logic      [2:0]        reinj_type_o,
   output logic      [63:0]       resume_ip_o
);
   import edt_pkg::*;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reinj_type_o <= 3'h0;
      end else if (trap_exc_i.valid) begin
         reinj_type_o <= (trap_exc_i.vector == 8'h03) ? 3'h3 : trap_exc_i.ev_type;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resume_ip_o <= 64'h0;
      end else if (trap_exc_i.valid) begin
         resume_ip_o <= trap_exc_i.ssa_ip;
      end
   end
endmodule

// >>> test/edt_gate_tb.sv
// Self-checking bench for the enclave debug and trace gating block.
`timescale 1ns/1ns
`include "edt_defines.svh"

module edt_gate_tb;
   import edt_pkg::*;

   logic         clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         wb_cyc_i = 1'b0;
   logic         wb_stb_i = 1'b0;
   logic         wb_we_i = 1'b0;
   logic [7:0]   wb_adr_i = 8'h0;
   logic [3:0]   wb_sel_i = 4'h0;
   logic [31:0]  wb_dat_i = 32'h0;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   edt_event_s   event_i = '0;
   logic [3:0]   ibp_match_i = 4'h0;
   logic [3:0]   aep_ibp_match_i = 4'h0;
   edt_daccess_s daccess_i = '0;
   logic         single_step_i = 1'b0;
   logic         trap_valid_i = 1'b0;
   logic [7:0]   trap_opcode_i = 8'h0;
   logic [63:0]  trap_ip_i = 64'h0;
   logic [3:0]   ibp_fire_o;
   logic [3:0]   dbp_fire_o;
   logic         aex_req_o;
   logic         btf_step_o;
   logic         lbr_suppress_o;
   edt_lbr_s     lbr_rec_o;
   edt_exc_s     trap_exc_o;
   logic [2:0]   reinj_type;
   logic [63:0]  resume_ip;
   int           errors = 0;
   int           n_tests = 0;
   edt_event_s   e;
   logic [63:0]  xip;

   always #20 clk_i = ~clk_i;

   edt_gate i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_i(event_i), .ibp_match_i(ibp_match_i),
      .aep_ibp_match_i(aep_ibp_match_i), .daccess_i(daccess_i), .single_step_i(single_step_i),
      .trap_valid_i(trap_valid_i), .trap_opcode_i(trap_opcode_i), .trap_ip_i(trap_ip_i),
      .ibp_fire_o(ibp_fire_o), .dbp_fire_o(dbp_fire_o), .aex_req_o(aex_req_o),
      .btf_step_o(btf_step_o), .lbr_suppress_o(lbr_suppress_o), .lbr_rec_o(lbr_rec_o),
      .trap_exc_o(trap_exc_o));

   edt_vmm_model i_vmm (.clk_i(clk_i), .rst_i(rst_i), .trap_exc_i(trap_exc_o),
      .reinj_type_o(reinj_type), .resume_ip_o(resume_ip));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wbw(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, s, d, q);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      wb(1'b0, a, 4'hf, 32'h0, q);
      chk(nm, {32'h0, x}, {32'h0, q});
   endtask

   task automatic ev(input edt_event_s x);
      @(posedge clk_i);
      event_i <= x;
      @(posedge clk_i);
      event_i.kind <= EDT_EV_NONE;
      #1;
   endtask

   function automatic logic [63:0] rip();
      return {1'b0, 31'($urandom), 32'($urandom)};
   endfunction

   function automatic logic [63:0] pred(input logic [63:0] ip);
      return ip | 64'h8000_0000_0000_0000;
   endfunction

   task automatic chk_rec(input logic [63:0] f, input logic [63:0] t);
      chk("rec_valid", 64'h1, {63'h0, lbr_rec_o.valid});
      chk("rec_from", f, lbr_rec_o.from_ip);
      chk("rec_to", t, lbr_rec_o.to_ip);
      chk("rec_far", {63'h0, f[63]}, {63'h0, lbr_rec_o.far_br});
      chk("rec_tx", 64'h0, {63'h0, lbr_rec_o.in_tx});
   endtask

   function automatic logic [3:0] exp_dbp(input logic oi, input edt_daccess_s d);
      // Page cache operands, except opt-in key/report leaves, and opt-out in-range accesses are silenced; implicit ones never fire.
      if (d.epc_operand) return (oi && d.keyrep_leaf && !d.implicit_acc) ? d.dbp_match : 4'h0;
      return (!oi && d.in_range) ? 4'h0 : d.dbp_match;
   endfunction

   task automatic bp_loop(input logic oi);
      edt_daccess_s d;
      logic [3:0]   m;
      for (int i = 0; i < 12; i++) begin
         d = edt_daccess_s'($urandom);
         d.valid = 1'b1;
         m = 4'($urandom);
         @(posedge clk_i);
         daccess_i <= d;
         ibp_match_i <= m;
         #1;
         chk("ibp_fire", {60'h0, oi ? m : 4'h0}, {60'h0, ibp_fire_o});
         chk("dbp_fire", {60'h0, exp_dbp(oi, d)}, {60'h0, dbp_fire_o});
      end
      daccess_i <= '0;
      ibp_match_i <= 4'h0;
   endtask

   task automatic trap_loop(input logic oi);
      logic [7:0]  ops [3];
      logic [63:0] ip;
      logic [63:0] ap;
      ops = '{`EDT_OPC_BKPT, `EDT_OPC_ICEBP, `EDT_OPC_INTN};
      for (int i = 0; i < 3; i++) begin
         ip = rip();
         ap = rip();
         @(posedge clk_i);
         trap_valid_i <= 1'b1;
         trap_opcode_i <= ops[i];
         trap_ip_i <= ip;
         event_i.async_exit_pointer <= ap;
         @(posedge clk_i);
         trap_valid_i <= 1'b0;
         #1;
         chk("trap_valid", {63'h0, i < 2}, {63'h0, trap_exc_o.valid});
         if (i < 2) begin
            chk("vector", {56'h0, oi ? (i == 0 ? 8'h03 : 8'h01) : 8'h06},
                {56'h0, trap_exc_o.vector});
            chk("ssa_ip", ip, trap_exc_o.ssa_ip);
            chk("stack_ip", ap, trap_exc_o.stack_ip);
            chk("ev_type", 64'h3, {61'h0, trap_exc_o.ev_type});
            chk("ilen", 64'h0, {60'h0, trap_exc_o.instr_len});
            chk("skip_dpl", {63'h0, oi && i == 0}, {63'h0, trap_exc_o.skip_dpl});
            @(posedge clk_i);
            #1;
            chk("resume_ip", ip, resume_ip);
         end
      end
   endtask

   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      end_of_test();
   end

   initial begin
      void'($urandom(63));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("ctrl_rst", `EDT_OFF_CTRL, `EDT_CTRL_RST);
      rdchk("unmapped", 8'h20, 32'h0);
      wbw(`EDT_OFF_CTRL, 4'h3, 32'h3);
      rdchk("ctrl", `EDT_OFF_CTRL, 32'h3);
      e = '0;
      e.kind = EDT_EV_ENTER;
      e.optin_flag = 1'b1;
      e.instr_ip = rip();
      e.dest_ip = rip();
      ev(e);
      chk_rec(pred(e.instr_ip), e.dest_ip);
      chk("btf_enter", 64'h1, {63'h0, btf_step_o});
      rdchk("status_in", `EDT_OFF_STATUS, 32'hb);
      rdchk("xstate_in", `EDT_OFF_EXITSTATE, 32'h2);
      bp_loop(1'b1);
      trap_loop(1'b1);
      chk("reinj", 64'h3, {61'h0, reinj_type});
      e.kind = EDT_EV_BRANCH;
      ev(e);
      chk_rec(e.instr_ip, e.dest_ip);
      e.kind = EDT_EV_AEX;
      e.ssa_ip = rip();
      e.async_exit_pointer = rip();
      ev(e);
      chk_rec(pred(e.ssa_ip), e.async_exit_pointer);
      chk("btf_aex", 64'h0, {63'h0, btf_step_o});
      e.kind = EDT_EV_RESUME;
      ev(e);
      chk("btf_resume", 64'h0, {63'h0, btf_step_o});
      e.kind = EDT_EV_EXIT;
      ev(e);
      chk_rec(pred(e.instr_ip), e.dest_ip);
      chk("btf_exit", 64'h1, {63'h0, btf_step_o});
      e.kind = EDT_EV_ENTER;
      e.optin_flag = 1'b0;
      xip = rip();
      e.instr_ip = xip;
      ev(e);
      chk("rec_none", 64'h0, {63'h0, lbr_rec_o.valid});
      chk("btf_out", 64'h0, {63'h0, btf_step_o});
      chk("suppress", 64'h1, {63'h0, lbr_suppress_o});
      rdchk("status_out", `EDT_OFF_STATUS, 32'hd);
      bp_loop(1'b0);
      trap_loop(1'b0);
      wbw(`EDT_OFF_DBGSTAT, 4'h1, 32'h0);
      single_step_i <= 1'b1;
      ibp_match_i <= 4'ha;
      aep_ibp_match_i <= 4'h5;
      #1;
      chk("aex_req", 64'h1, {63'h0, aex_req_o});
      e.kind = EDT_EV_AEX;
      e.cause_push = 1'b1;
      e.cause_to = rip();
      e.rf_push = 1'b1;
      ev(e);
      single_step_i <= 1'b0;
      ibp_match_i <= 4'h0;
      chk_rec(pred(xip), e.async_exit_pointer);
      @(posedge clk_i);
      #1;
      chk("cause_from", {1'b0, e.async_exit_pointer[62:0]}, {1'b0, lbr_rec_o.from_ip[62:0]});
      chk("cause_to", e.cause_to, lbr_rec_o.to_ip);
      chk("unsuppress", 64'h0, {63'h0, lbr_suppress_o});
      rdchk("dbgstat", `EDT_OFF_DBGSTAT, 32'h5);
      rdchk("xstate_aex", `EDT_OFF_EXITSTATE, 32'h1);
      e.kind = EDT_EV_ENTER;
      e.dest_ip = rip();
      ev(e);
      rdchk("dbgstat_kept", `EDT_OFF_DBGSTAT, 32'h5);
      e.kind = EDT_EV_EXIT;
      ev(e);
      chk_rec(pred(xip), e.dest_ip);
      wbw(`EDT_OFF_CTRL, 4'h3, 32'h103);
      e.kind = EDT_EV_ENTER;
      e.optin_flag = 1'b1;
      ev(e);
      chk("far_filter", 64'h0, {63'h0, lbr_rec_o.valid});
      end_of_test();
   end
endmodule
